// >>> host_scanner.sv
// Host controller model: drives scan and hold pins, reads the image.
// Assumes the bench requests scans and holds as levels.
`timescale 1ns/1ps
module host_scanner
(
   input wire logic core_clk, // Core clock
   input wire logic scan_go, // Bench scan request
   input wire logic hold_go, // Bench hold request
   input wire logic [31:0] input_image, // Image from module
   input wire logic image_update, // New image
   output logic host_scan_pin, // Scan pin
   output logic host_hold_pin, // Hold pin
   output logic [1:0] host_chan, // Channel of last word
   output logic [15:0] host_mag // Magnitude of last word
);
   initial
   begin
      host_scan_pin = 1'b0;
      host_hold_pin = 1'b0;
   end
   // Pins change on the falling edge
   always @(negedge core_clk)
   begin
      host_scan_pin <= scan_go;
      host_hold_pin <= hold_go;
   end
   always @(posedge core_clk)
   begin
      if (image_update)
      begin
         host_chan <= input_image[17:16];
         host_mag <= input_image[15:0] & 16'h7FFF;
      end
   end
endmodule : host_scanner

// >>> sensor_input_word.sv
// Multiplexed 32-point input image of a four-channel sensor input module.
// Assumes converter results arrive on core_clk; open-sensor and host pins are asynchronous.
`timescale 1ns/1ps
module sensor_input_word
   import sensor_word_pkg::*;
#(
   parameter int CONV_CNT = CONV_CYCLES,  // Cycles per channel conversion
   parameter int BUF_DEPTH = 2            // Entries in the output buffer
)
(
   input wire logic core_clk,                     // 200 MHz core clock
   input wire logic reset_n,                      // Async reset, active low
   input wire logic [NUM_CH*DATA_W-1:0] conv_values, // Signed tenths per channel
   input wire logic [NUM_CH-1:0] open_pin,        // Open-sensor detectors, async
   input wire logic host_scan_pin,                // Host scan request, async
   input wire logic host_hold_pin,                // Host reading image, async
   input wire logic [NUM_CH-1:0] chan_enable,     // Channels in use
   input wire logic format_twos,                  // 1 two's complement, 0 mag+sign
   input wire logic bipolar,                      // Bipolar input range
   input wire logic mux_mode,                     // Host reads multiplexed
   output logic [IMAGE_W-1:0] input_image,        // Image seen by the host
   output logic image_update,                     // Image changed this cycle
   output logic scan_missed,                      // Scan lost to back-pressure
   output logic conv_done                         // A conversion was stored
);

   localparam int CNT_W = $clog2(CONV_CNT + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CNT - 1);

   typedef enum logic
   {
      SCAN_IDLE,
      SCAN_PUSH
   } scan_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [NUM_CH-1:0] open_meta;
   logic [NUM_CH-1:0] open_sync;
   logic scan_meta;
   logic scan_sync;
   logic scan_prev;
   logic hold_meta;
   logic hold_sync;
   logic scan_pulse;

   // Two flops on every asynchronous pin
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         open_meta <= '0;
         open_sync <= '0;
         scan_meta <= 1'b0;
         scan_sync <= 1'b0;
         hold_meta <= 1'b0;
         hold_sync <= 1'b0;
      end
      else
      begin
         open_meta <= open_pin;
         open_sync <= open_meta;
         scan_meta <= host_scan_pin;
         scan_sync <= scan_meta;
         hold_meta <= host_hold_pin;
         hold_sync <= hold_meta;
      end
   end

   // Scan edge detect on the synchronised level
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         scan_prev <= 1'b0;
      else
         scan_prev <= scan_sync;
   end

   assign scan_pulse = scan_sync && !scan_prev;

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer

   logic [CNT_W-1:0] conv_cnt;
   logic [CH_W-1:0] conv_ch;
   logic conv_tick;
   logic signed [DATA_W-1:0] result [NUM_CH];
   logic [NUM_CH-1:0] result_ok;
   logic conv_store;

   assign conv_tick = (conv_cnt == CNT_LAST) && (chan_enable != '0);
   // A tick on a channel still in use stores a reading
   assign conv_store = conv_tick && chan_enable[conv_ch];

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         conv_cnt <= '0;
      else if (chan_enable == '0 || conv_tick)
         conv_cnt <= '0;
      else
         conv_cnt <= conv_cnt + 1'b1;
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         conv_ch <= FIRST_CH;
      else if (chan_enable != '0 && !chan_enable[conv_ch])
         conv_ch <= next_chan(conv_ch, chan_enable);
      else if (conv_tick)
         conv_ch <= next_chan(conv_ch, chan_enable);
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < NUM_CH; i++)
            result[i] <= '0;
      end
      else if (conv_store)
         result[conv_ch] <= conv_values[conv_ch*DATA_W +: DATA_W];
   end

   // Conversion stored pulse
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         conv_done <= 1'b0;
      else
         conv_done <= conv_store;
   end

   // Valid flags: dropped channels forget, a store in the same cycle wins
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         result_ok <= '0;
      else
      begin
         result_ok <= result_ok & chan_enable;
         if (conv_store)
            result_ok[conv_ch] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word formatting

   logic [DATA_W-1:0] abs_val;
   logic [DATA_W-1:0] data_word;
   logic signed [DATA_W-1:0] sel_val;
   logic [CH_W-1:0] scan_ch;
   logic [IMAGE_W-1:0] next_image;

   assign sel_val = result_ok[scan_ch] ? result[scan_ch] : $signed(DATA_ZERO);

   // Magnitude of the reading, negated when negative, saturated to 15 bits
   always_comb
   begin
      abs_val = sel_val[SIGN_BIT] ? DATA_W'(-sel_val) : DATA_W'(sel_val);
      if (abs_val > MAG_MAX)
         abs_val = MAG_MAX;
   end

   // Choose the data format for the word
   always_comb
   begin
      if (!bipolar)
         data_word = sel_val[SIGN_BIT] ? DATA_ZERO : DATA_W'(sel_val);
      else if (fmt_t'(format_twos) == FMT_TWOS)
         data_word = DATA_W'(sel_val);
      else if (sel_val[SIGN_BIT])
         data_word = SIGN_MASK | abs_val;
      else
         data_word = abs_val;
   end

   always_comb
   begin
      next_image = IMAGE_RESET;
      next_image[DATA_LSB +: DATA_W] = data_word;
      next_image[CHAN_LSB +: CH_W] = scan_ch;
      next_image[OPEN_LSB +: NUM_CH] = mux_mode ? open_sync : '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Host scan engine

   scan_state_t scan_state;
   logic buf_in_valid;
   logic buf_in_ready;
   logic [IMAGE_W-1:0] buf_in_data;
   logic buf_out_valid;
   logic buf_out_ready;
   logic [IMAGE_W-1:0] buf_out_data;
   logic first_scan;

   // One channel per scan, held while buffer is full
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         scan_state <= SCAN_IDLE;
         scan_ch <= FIRST_CH;
         first_scan <= 1'b1;
         scan_missed <= 1'b0;
         buf_in_valid <= 1'b0;
         buf_in_data <= IMAGE_RESET;
      end
      else
      begin
         scan_missed <= 1'b0;
         unique case (scan_state)
            SCAN_IDLE:
            begin
               if (scan_pulse && chan_enable != '0)
               begin
                  if (first_scan && chan_enable[FIRST_CH])
                     scan_ch <= FIRST_CH;
                  else
                     scan_ch <= next_chan(scan_ch, chan_enable);
                  first_scan <= 1'b0;
                  scan_state <= SCAN_PUSH;
               end
            end
            SCAN_PUSH:
            begin
               // Capture all fields in one register
               if (!buf_in_valid)
               begin
                  buf_in_data <= next_image;
                  buf_in_valid <= 1'b1;
               end
               else if (buf_in_ready)
               begin
                  buf_in_valid <= 1'b0;
                  scan_state <= SCAN_IDLE;
               end
               if (scan_pulse)
                  scan_missed <= 1'b1;
            end
         endcase
      end
   end

   word_buffer #(
      .WIDTH(IMAGE_W),
      .DEPTH(BUF_DEPTH)
   ) u_buffer (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Host-facing image register

   // Host reading the image stalls the buffer
   assign buf_out_ready = !hold_sync;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         input_image <= IMAGE_RESET;
         image_update <= 1'b0;
      end
      else
      begin
         image_update <= buf_out_valid && buf_out_ready;
         if (buf_out_valid && buf_out_ready)
            input_image <= buf_out_data;
      end
   end

endmodule : sensor_input_word

// >>> sensor_word_pkg.sv
// Constants, field layout and helpers for the sensor input word formatter.
// Assumes a single 200 MHz core clock shared by all users of this package.
package sensor_word_pkg;

   // Channel and word geometry
   localparam int NUM_CH = 4;
   localparam int CH_W = 2;
   localparam int DATA_W = 16;
   localparam int IMAGE_W = 32;

   // Field positions inside the 32-point input image
   localparam int DATA_LSB = 0;
   localparam int CHAN_LSB = 16;
   localparam int OPEN_LSB = 24;
   localparam int SIGN_BIT = 15;

   // Value limits and reset contents
   localparam logic [DATA_W-1:0] SIGN_MASK = 16'h8000;
   localparam logic [DATA_W-1:0] MAG_MAX = 16'h7FFF;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [IMAGE_W-1:0] IMAGE_RESET = 32'h0000_0000;
   localparam logic [CH_W-1:0] FIRST_CH = 2'h0;

   // Timing: conversion time per enabled channel
   localparam int CLK_KHZ = 200000;
   localparam int CONV_TIME_MS = 160;
   localparam int CONV_CYCLES = CONV_TIME_MS * CLK_KHZ;

   // Output data formats
   typedef enum logic
   {
      FMT_MAG_SIGN,
      FMT_TWOS
   } fmt_t;

   // Next enabled channel after cur, wrapping past channel 3 to channel 0
   function automatic logic [CH_W-1:0] next_chan(input logic [CH_W-1:0] cur,
                                                 input logic [NUM_CH-1:0] en);
      logic found;
      logic [CH_W-1:0] idx;
      found = 1'b0;
      next_chan = cur;
      for (int i = 1; i <= NUM_CH; i++)
      begin
         idx = cur + CH_W'(i);
         if (!found && en[idx])
         begin
            next_chan = idx;
            found = 1'b1;
         end
      end
   endfunction : next_chan

endpackage : sensor_word_pkg

// >>> sensor_word_sva.sv
// Checker for the sensor input word formatter, bound to its top module.
// Assumes one core clock and the async active-low reset of the design.
`timescale 1ns/1ps
module sensor_word_sva
   import sensor_word_pkg::*;
#(
   parameter int CONV_CNT = 20 // Cycles per conversion
)
(
   input wire logic core_clk, // Core clock
   input wire logic reset_n, // Async reset
   input wire logic [3:0] open_pin, // Open-sensor levels
   input wire logic host_scan_pin, // Host scan
   input wire logic host_hold_pin, // Host hold
   input wire logic [3:0] chan_enable, // Channels in use
   input wire logic format_twos, // Data format
   input wire logic bipolar, // Bipolar range
   input wire logic mux_mode, // Multiplexed read
   input wire logic [31:0] input_image, // Host image
   input wire logic image_update, // New image
   input wire logic conv_done // Conversion stored
);
   int cnt;
   logic seen;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////
   // Cycles since the last stored conversion
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 0;
         seen <= 1'b0;
      end
      else
      begin
         cnt <= conv_done ? 0 : cnt + 1;
         seen <= conv_done ? 1'b1 : ($changed(chan_enable) ? 1'b0 : seen);
      end
   end
   property p_conv; conv_done && seen |-> cnt == CONV_CNT - 1; endproperty
   a_conv: assert property (p_conv) else $error("conversion period wrong");
   property p_change; $changed(input_image) |-> image_update; endproperty
   a_change: assert property (p_change) else $error("image changed silently");
   property p_spare; input_image[31:28] == 4'h0 && input_image[23:18] == 6'h00; endproperty
   a_spare: assert property (p_spare) else $error("spare image bits set");
   property p_hold; host_hold_pin [*5] |-> !image_update; endproperty
   a_hold: assert property (p_hold) else $error("image updated during hold");
   property p_omask; image_update && !mux_mode && !$past(mux_mode, 8) |->
      input_image[27:24] == 4'h0; endproperty
   a_omask: assert property (p_omask) else $error("open bits outside mux mode");
   property p_open; image_update && mux_mode && $past(mux_mode, 10) &&
      $past(open_pin, 10) == open_pin |-> input_image[27:24] == open_pin; endproperty
   a_open: assert property (p_open) else $error("open bits wrong");
   property p_chan; image_update |-> chan_enable[input_image[17:16]]; endproperty
   a_chan: assert property (p_chan) else $error("disabled channel shown");
   property p_sign; image_update && bipolar && !format_twos && input_image[15] |->
      input_image[14:0] != 15'h0000; endproperty
   a_sign: assert property (p_sign) else $error("sign without magnitude");
   property p_scan; $rose(host_scan_pin) && !host_hold_pin && !$past(host_hold_pin) &&
      chan_enable != 4'h0 |-> ##[4:8] image_update; endproperty
   a_scan: assert property (p_scan) else $error("scan not answered");
endmodule : sensor_word_sva
bind sensor_input_word sensor_word_sva #(.CONV_CNT(CONV_CNT)) u_sva (.core_clk(core_clk),
   .reset_n(reset_n), .open_pin(open_pin), .host_scan_pin(host_scan_pin),
   .host_hold_pin(host_hold_pin), .chan_enable(chan_enable), .format_twos(format_twos),
   .bipolar(bipolar), .mux_mode(mux_mode), .input_image(input_image),
   .image_update(image_update), .conv_done(conv_done));

// >>> tb_sensor_input_word.sv
// Self-checking bench for the sensor input word formatter.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_sensor_input_word
   import sensor_word_pkg::*;
   ;
   logic core_clk, reset_n, format_twos, bipolar, mux_mode, scan_go, hold_go;
   logic [63:0] conv_values;
   logic [3:0] open_pin, chan_enable;
   logic host_scan_pin, host_hold_pin, image_update, conv_done, scan_missed, host_due;
   logic [31:0] exp_w;
   logic [1:0] host_chan;
   logic [15:0] host_mag;
   logic [31:0] input_image, rng;
   logic [31:0] expq[$];
   logic [1:0] last;
   int errors, checks_done, missed_seen, missed_exp;
   logic [3:0] en_t [5] = '{4'hF, 4'hF, 4'hF, 4'hA, 4'h6};
   logic [4:0] twos_t = 5'b10010;
   logic [4:0] bip_t = 5'b11011;
   logic [4:0] mux_t = 5'b01011;
   ////////////////////////////////////////////////////////////////
   sensor_input_word #(.CONV_CNT(20)) dut (.core_clk(core_clk), .reset_n(reset_n),
      .conv_values(conv_values), .open_pin(open_pin), .host_scan_pin(host_scan_pin),
      .host_hold_pin(host_hold_pin), .chan_enable(chan_enable), .format_twos(format_twos),
      .bipolar(bipolar), .mux_mode(mux_mode), .input_image(input_image),
      .image_update(image_update), .scan_missed(scan_missed), .conv_done(conv_done));
   host_scanner host (.core_clk(core_clk), .scan_go(scan_go), .hold_go(hold_go),
      .input_image(input_image), .image_update(image_update), .host_scan_pin(host_scan_pin),
      .host_hold_pin(host_hold_pin), .host_chan(host_chan), .host_mag(host_mag));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // Expected data word for one reading
   function automatic logic [15:0] fmtv(input logic [15:0] v, input logic tw, input logic bp);
      logic [15:0] m;
      m = v[15] ? 16'h0000 - v : v;
      if (m > 16'h7FFF)
         m = 16'h7FFF;
      if (!bp)
         return v[15] ? 16'h0000 : v;
      if (tw || !v[15])
         return v;
      return 16'h8000 | m;
   endfunction : fmtv
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: image %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   // One host scan with its expected word noted
   task automatic scan(input bit rnd, input bit drop);
      logic [1:0] c;
      if (rnd)
      begin
         rng = xs(rng);
         open_pin = rng[3:0];
      end
      repeat (4) @(negedge core_clk);
      c = last;
      for (int i = 0; i < 4; i++)
      begin
         c = c + 2'h1;
         if (chan_enable[c])
            break;
      end
      // A refused scan leaves the channel sequence where it was
      if (drop)
         missed_exp++;
      else
      begin
         last = c;
         expq.push_back({4'h0, mux_mode ? open_pin : 4'h0, 6'h00, c,
            fmtv(conv_values[c*16 +: 16], format_twos, bipolar)});
      end
      scan_go <= 1'b1;
      repeat (3) @(negedge core_clk);
      scan_go <= 1'b0;
      repeat (9) @(negedge core_clk);
   endtask : scan
   ////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Compare each new image with the oldest note, the host's view one cycle later
   always @(negedge core_clk)
   begin
      if (host_due === 1'b1)
         check(32'({host_chan, host_mag}), 32'({exp_w[17:16], 1'b0, exp_w[14:0]}));
      host_due = 1'b0;
      if (scan_missed === 1'b1)
         missed_seen++;
      if (image_update === 1'b1)
      begin
         if (expq.size() == 0)
         begin
            errors++;
            $display("mismatch at %0t: unexpected image", $time);
         end
         else
         begin
            exp_w = expq.pop_front();
            check(input_image, exp_w);
            host_due = 1'b1;
         end
      end
   end
   initial
   begin
      repeat (5000) @(negedge core_clk);
      errors++;
      $display("mismatch at %0t: run timed out", $time);
      report_and_stop();
   end
   initial
   begin
      {reset_n, format_twos, bipolar, mux_mode, scan_go, hold_go} = 6'h00;
      {conv_values, open_pin, chan_enable} = '0;
      errors = 0;
      checks_done = 0;
      missed_seen = 0;
      missed_exp = 0;
      host_due = 1'b0;
      rng = 32'h0000BFC1;
      last = 2'h3;
      repeat (4) @(negedge core_clk);
      reset_n = 1'b1;
      // Formats, ranges, modes and channel masks
      for (int i = 0; i < 5; i++)
      begin
         chan_enable = en_t[i];
         format_twos = twos_t[i];
         bipolar = bip_t[i];
         mux_mode = mux_t[i];
         rng = xs(rng);
         conv_values = {16'h8000, rng[15:0], 16'hFFFE, 16'h2122};
         repeat (100) @(negedge core_clk);
         repeat (5) scan(1'b1, 1'b0);
         $display("test %0d done", i);
      end
      // Two words wait in the buffer, a third stalls the engine, a fourth is refused
      hold_go <= 1'b1;
      repeat (6) @(negedge core_clk);
      repeat (3) scan(1'b0, 1'b0);
      scan(1'b0, 1'b1);
      repeat (10) @(negedge core_clk);
      hold_go <= 1'b0;
      for (int k = 0; k < 200 && expq.size() > 0; k++)
         @(negedge core_clk);
      // Let the host view of the last word be compared
      repeat (2) @(negedge core_clk);
      if (expq.size() != 0)
      begin
         errors++;
         $display("mismatch at %0t: images missing", $time);
      end
      check(32'(missed_seen), 32'(missed_exp));
      $display("hold test done");
      report_and_stop();
   end
endmodule : tb_sensor_input_word

// >>> word_buffer.sv
// Two-entry word buffer with valid/ready on both sides.
// Assumes source and sink share core_clk; full refuses writes, empty offers nothing.
`timescale 1ns/1ps
module word_buffer
   import sensor_word_pkg::*;
#(
   parameter int WIDTH = 32,
   parameter int DEPTH = 2
)
(
   input wire logic core_clk,            // Core clock
   input wire logic reset_n,             // Async reset, active low
   input wire logic in_valid,            // Source offers a word
   output logic in_ready,                // Buffer can take a word
   input wire logic [WIDTH-1:0] in_data, // Word from source
   output logic out_valid,               // Buffer holds a word
   input wire logic out_ready,           // Sink takes the word
   output logic [WIDTH-1:0] out_data     // Oldest word
);

   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
   localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [PTR_W:0] count;
   logic push;
   logic pop;

   // Handshake terms
   assign in_ready = (count != DEPTH_CNT);
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = store[rd_ptr];

   // Storage writes
   always_ff @(posedge core_clk)
   begin
      if (push)
         store[wr_ptr] <= in_data;
   end

   // Pointers and fill count
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
            wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end

endmodule : word_buffer
